// File: src/hbp_defines.svh
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH

// ****************************************************************
// Direct register word addresses (byte offsets 0x00 to 0x0C).
// ****************************************************************
`define HBP_ADR_INDADDR 2'h0
`define HBP_ADR_INDDATA 2'h1
`define HBP_ADR_CDATA   2'h2
`define HBP_ADR_INTSTAT 2'h3

// ****************************************************************
// Widths, FIFO shape and thresholds.
// ****************************************************************
`define HBP_DATA_W      32
`define HBP_HALF_W      16
`define HBP_FIFO_D      32
`define HBP_LVL_W       6
`define HBP_NEAR_FULL   6'h18
`define HBP_NEAR_EMPTY  6'h08
`define HBP_IDX_W       8
`define HBP_IDX_STEP    8'h01
`define HBP_IDX_RST     8'h00
`define HBP_SRQ_BIT     0
`define HBP_EN_ON       2'h0
`define HBP_EN_OFF      2'h3

`endif

// File: src/hbp_pkg.sv
`include "hbp_defines.svh"

package hbp_pkg;

  // ****************************************************************
  // Access sequencer states, Gray coded along idle, wait, acknowledge.
  // ****************************************************************
  typedef enum logic [1:0]
  {
    HBP_IDLE = 2'h0,
    HBP_WAIT = 2'h1,
    HBP_ACK  = 2'h3
  } hbp_state_t;

  // ****************************************************************
  // Host pins as seen by the port, all sampled on ref_clk.
  // ****************************************************************
  typedef struct packed
  {
    logic                      csN;
    logic                      wrN;
    logic                      rdN;
    logic [1:0]                adr;
    logic [1:0]                lowerHalfEnableN;
    logic [1:0]                upperHalfEnableN;
    logic [`HBP_DATA_W-1:0]    data;
  } hbp_host_t;

  // ****************************************************************
  // Register access presented to the core register file.
  // ****************************************************************
  typedef struct packed
  {
    logic                      wrEn;
    logic                      rdEn;
    logic [1:0]                adr;
    logic [`HBP_IDX_W-1:0]     index;
    logic                      lowerHalf;
    logic                      upperHalf;
    logic [`HBP_DATA_W-1:0]    data;
  } hbp_reg_t;

endpackage

// File: src/hbp_fifo.sv
`timescale 1ns/10ps

module hbp_fifo
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
)
(
  // Clock and reset.
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       flush,
  // Fill side.
  input  wire logic [WIDTH-1:0]           inData,
  input  wire logic                       inValid,
  output logic                            inReady,
  // Drain side.
  output logic [WIDTH-1:0]                outData,
  output logic                            outValid,
  input  wire logic                       outReady,
  // Occupancy.
  output logic [$clog2(DEPTH):0]          level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outReady && outValid;
  assign outData  = mem[rdPtr_q];
  assign level    = count_q;

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop)
      begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule // hbp_fifo

// File: src/hbp_host_port.sv
// Summary of operation
// (RL1) Lower enable pair selects the low 16-bit half, upper pair the high half.
// (RL2) A full-width host keeps both enable pairs low at all times.
// (RL3) A 16-bit host always moves the lower half before the upper half.
// (RL4) The FIFO steps to the next word only after an upper-half access ends.
// (RL5) The indirect index steps only after the upper half of indirect data.
// (RL6) Strobes act only while select is low; the host selects every access.
// (RL7) With select high all 32 data pins are released.
// (RL8) Write data is taken at the rising edge of the write strobe.
// (RL9) Read data is driven for as long as the read strobe is low.
// (RL10) Acknowledge is asserted to complete each access.
// (RL11) Non-FIFO accesses hold acknowledge off for at least one wait cycle.
// (RL12) Decoding with a full FIFO, acknowledge stays off until a slot frees.
// (RL13) Encoding with an empty FIFO, acknowledge stays off until a word arrives.
// (RL14) Service request is high whenever the FIFO needs the host.
// (RL15) Service request is mirrored in status and gated by mask onto the interrupt.
// (RL16) The host holds its strobe until acknowledge, then ends the access.
// (RL17) Two address pins select one of four registers at 0x00 to 0x0C.
// (RL18) Encoding, service request is low after soft reset and rises when nearly full.
`timescale 1ns/10ps
`include "hbp_defines.svh"

module hbp_host_port
(
  // Clock and reset.
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // Host bus.
  input  wire hbp_pkg::hbp_host_t       hostIn,
  output logic [`HBP_DATA_W-1:0]        dataOut,
  output logic [`HBP_DATA_W-1:0]        dataOeN,
  output logic                          ackN,
  output logic                          bufferServiceRequest,
  output logic                          hostInterrupt,
  // Core control.
  input  wire logic                     encodeMode,
  input  wire logic                     softResetBit,
  input  wire logic                     srqMask,
  // Core register file.
  output hbp_pkg::hbp_reg_t             coreAcc,
  input  wire logic [`HBP_DATA_W-1:0]   coreRdData,
  // Encode stream into the FIFO.
  input  wire logic [`HBP_DATA_W-1:0]   strmInData,
  input  wire logic                     strmInValid,
  output logic                          strmInReady,
  // Decode stream out of the FIFO.
  output logic [`HBP_DATA_W-1:0]        strmOutData,
  output logic                          strmOutValid,
  input  wire logic                     strmOutReady
);
  import hbp_pkg::*;

  // ****************************************************************
  // Access decode.
  // ****************************************************************
  hbp_state_t               state_q;
  hbp_state_t               state_d;
  logic                     accReq;
  logic                     isWr;
  logic                     isData;
  logic                     lowSel;
  logic                     upSel;
  logic                     fifoBlock;
  logic                     commit;
  logic                     accWr_q;
  logic [1:0]               accAdr_q;
  logic                     accLow_q;
  logic                     accUp_q;
  logic [`HBP_DATA_W-1:0]   wrData_q;
  logic [`HBP_HALF_W-1:0]   stage_q;
  logic [`HBP_IDX_W-1:0]    indPtr_q;
  logic                     pushHost;
  logic                     popHost;
  logic [`HBP_DATA_W-1:0]   fInData;
  logic                     fInValid;
  logic                     fInReady;
  logic [`HBP_DATA_W-1:0]   fOutData;
  logic                     fOutValid;
  logic                     fOutReady;
  logic [`HBP_LVL_W-1:0]    level;

  function automatic logic pairOn(input logic [1:0] enN);
    pairOn = (enN == `HBP_EN_ON);
  endfunction

  assign accReq = !hostIn.csN && (!hostIn.wrN || !hostIn.rdN); // RL6
  assign isWr   = !hostIn.wrN;
  assign isData = (hostIn.adr == `HBP_ADR_CDATA); // RL17
  assign lowSel = pairOn(hostIn.lowerHalfEnableN); // RL1 RL2
  assign upSel  = pairOn(hostIn.upperHalfEnableN); // RL1 RL2
  assign fifoBlock = encodeMode ? (!isWr && !fOutValid) // RL13
                                : (isWr && !fInReady); // RL12
  assign commit = (state_q == HBP_ACK) && hostIn.wrN && hostIn.rdN; // RL16

  // ****************************************************************
  // Access sequencer.
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      HBP_IDLE:
      begin
        if (accReq && !isData)
        begin
          state_d = HBP_WAIT; // RL11
        end
        else if (accReq && !fifoBlock)
        begin
          state_d = HBP_ACK;
        end
      end
      HBP_WAIT: state_d = HBP_ACK;
      HBP_ACK:
      begin
        if (commit)
        begin
          state_d = HBP_IDLE;
        end
      end
      default: state_d = HBP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    state_q <= rst ? HBP_IDLE : state_d;
  end

  assign ackN = (state_q != HBP_ACK); // RL10

  // ****************************************************************
  // Access attributes, latched when the access is accepted.
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      accWr_q  <= 1'b0;
      accAdr_q <= `HBP_ADR_INDADDR;
      accLow_q <= 1'b0;
      accUp_q  <= 1'b0;
    end
    else if (state_q == HBP_IDLE && accReq)
    begin
      accWr_q  <= isWr;
      accAdr_q <= hostIn.adr;
      accLow_q <= lowSel;
      accUp_q  <= upSel;
    end
  end

  // Data in the last cycle with write low is what the rising edge captures.
  always_ff @(posedge ref_clk)
  begin
    if (!hostIn.wrN)
    begin
      wrData_q <= hostIn.data; // RL8
    end
  end

  // ****************************************************************
  // Compressed data: half staging and FIFO stepping.
  // ****************************************************************
  assign pushHost = commit && accWr_q && accUp_q && !encodeMode
                    && (accAdr_q == `HBP_ADR_CDATA); // RL4 RL3
  assign popHost  = commit && !accWr_q && accUp_q && encodeMode
                    && (accAdr_q == `HBP_ADR_CDATA); // RL4

  always_ff @(posedge ref_clk)
  begin
    if (commit && accWr_q && accLow_q && (accAdr_q == `HBP_ADR_CDATA))
    begin
      stage_q <= wrData_q[`HBP_HALF_W-1:0]; // RL3
    end
  end

  assign fInData = encodeMode ? strmInData
                              : {wrData_q[`HBP_DATA_W-1:`HBP_HALF_W],
                                 accLow_q ? wrData_q[`HBP_HALF_W-1:0] : stage_q};

  assign fInValid     = encodeMode ? strmInValid : pushHost;
  assign fOutReady    = encodeMode ? popHost : strmOutReady;
  assign strmInReady  = encodeMode && fInReady;
  assign strmOutValid = !encodeMode && fOutValid;
  assign strmOutData  = fOutData;

  hbp_fifo
  #(
    .WIDTH (`HBP_DATA_W),
    .DEPTH (`HBP_FIFO_D)
  )
  uFifo
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .flush    (softResetBit),
    .inData   (fInData),
    .inValid  (fInValid),
    .inReady  (fInReady),
    .outData  (fOutData),
    .outValid (fOutValid),
    .outReady (fOutReady),
    .level    (level)
  );

  // ****************************************************************
  // Indirect register index.
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      indPtr_q <= `HBP_IDX_RST;
    end
    else if (commit && accWr_q && accAdr_q == `HBP_ADR_INDADDR)
    begin
      indPtr_q <= wrData_q[`HBP_IDX_W-1:0];
    end
    else if (commit && accUp_q && accAdr_q == `HBP_ADR_INDDATA)
    begin
      indPtr_q <= indPtr_q + `HBP_IDX_STEP; // RL5
    end
  end

  // ****************************************************************
  // Core register access and read data path.
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      coreAcc <= '0;
    end
    else
    begin
      coreAcc.wrEn      <= commit && accWr_q && (accAdr_q != `HBP_ADR_CDATA); // RL8
      coreAcc.rdEn      <= (state_q == HBP_WAIT) && !accWr_q;
      coreAcc.adr       <= (state_q == HBP_IDLE) ? hostIn.adr : accAdr_q;
      coreAcc.index     <= indPtr_q;
      coreAcc.lowerHalf <= accLow_q; // RL1
      coreAcc.upperHalf <= accUp_q; // RL1
      coreAcc.data      <= wrData_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dataOut <= '0;
      dataOeN <= '1;
    end
    else
    begin
      dataOeN <= {`HBP_DATA_W{hostIn.csN || hostIn.rdN}}; // RL7 RL9
      dataOut <= coreRdData;
      if (hostIn.adr == `HBP_ADR_CDATA)
      begin
        dataOut <= fOutData;
      end
      else if (hostIn.adr == `HBP_ADR_INTSTAT)
      begin
        dataOut <= coreRdData
                   | ({{(`HBP_DATA_W-1){1'b0}}, bufferServiceRequest} << `HBP_SRQ_BIT); // RL15
      end
    end
  end

  // ****************************************************************
  // Service request and host interrupt.
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst || softResetBit)
    begin
      bufferServiceRequest <= !encodeMode; // RL18
    end
    else if (encodeMode)
    begin
      bufferServiceRequest <= (level >= `HBP_NEAR_FULL); // RL14 RL18
    end
    else
    begin
      bufferServiceRequest <= (level <= `HBP_NEAR_EMPTY); // RL14
    end
  end

  always_ff @(posedge ref_clk)
  begin
    hostInterrupt <= !rst && bufferServiceRequest && srqMask; // RL15
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_cs_gate: assert property ( // RL6
    (state_q == HBP_IDLE && hostIn.csN) |=> ackN && state_q != HBP_WAIT)
    else $error("Access started without select.");
  chk_wait_cycle: assert property ( // RL11
    (state_q == HBP_IDLE && accReq && !isData) |=> ackN ##1 !ackN)
    else $error("Register access skipped its wait cycle.");
  chk_full_stall: assert property ( // RL12
    (state_q == HBP_IDLE && accReq && isData && isWr && !encodeMode && !fInReady) |=> ackN)
    else $error("Write acknowledged into a full FIFO.");
  chk_empty_stall: assert property ( // RL13
    (state_q == HBP_IDLE && accReq && isData && !isWr && encodeMode && !fOutValid) |=> ackN)
    else $error("Read acknowledged from an empty FIFO.");
  chk_bus_release: assert property ( // RL7
    hostIn.csN |=> (dataOeN == '1))
    else $error("Data bus driven while deselected.");
  chk_read_drive: assert property ( // RL9
    (!hostIn.csN && !hostIn.rdN)[*2] |-> (dataOeN == '0))
    else $error("Data bus released during a read.");
  chk_fifo_step: assert property ( // RL4
    (fInValid && !encodeMode) || (fOutReady && encodeMode) |-> accUp_q && commit)
    else $error("FIFO stepped without an upper half access.");
  chk_index_step: assert property ( // RL5
    (commit && accAdr_q == `HBP_ADR_INDDATA) |=>
      indPtr_q == $past(indPtr_q) + ($past(accUp_q) ? `HBP_IDX_STEP : `HBP_IDX_RST))
    else $error("Indirect index stepped wrongly.");
  chk_srq_level: assert property ( // RL14 RL18
    (encodeMode && !softResetBit && level >= `HBP_NEAR_FULL) ##1 encodeMode
      |-> bufferServiceRequest)
    else $error("Service request missing at nearly full.");
  chk_irq_mask: assert property ( // RL15
    hostInterrupt |-> $past(bufferServiceRequest) && $past(srqMask))
    else $error("Interrupt raised without masked request.");
  chk_write_take: assert property ( // RL8
    (commit && accWr_q && accAdr_q != `HBP_ADR_CDATA) |=> coreAcc.wrEn ##1 !coreAcc.wrEn)
    else $error("Register write not issued once.");

endmodule // hbp_host_port

// File: sim/hbp_host_model.sv
`timescale 1ns/10ps
`include "hbp_defines.svh"

module hbp_host_model
(
  // Clock.
  input  wire logic                     ref_clk,
  // Device side of the host bus.
  input  wire logic [`HBP_DATA_W-1:0]   dataOut,
  input  wire logic [`HBP_DATA_W-1:0]   dataOeN,
  input  wire logic                     ackN,
  output hbp_pkg::hbp_host_t            hostIn
);
  import hbp_pkg::*;

  logic [`HBP_DATA_W-1:0] busLvl;

  // The wire shows the device where it drives and the host elsewhere.
  assign busLvl = (~dataOeN & dataOut) | (dataOeN & hostIn.data);

  initial
  begin
    hostIn = '0;
    hostIn.csN = 1'b1;
    hostIn.wrN = 1'b1;
    hostIn.rdN = 1'b1;
    hostIn.lowerHalfEnableN = `HBP_EN_OFF;
    hostIn.upperHalfEnableN = `HBP_EN_OFF;
    hostIn.data = 32'h5A5A_A5A5;
  end

  // ****************************************************************
  // One host access; n is the wait in cycles, 99 when it hangs.
  // ****************************************************************
  task automatic access(input logic wr, input logic [1:0] adr, input logic [1:0] loN,
                        input logic [1:0] upN, input logic [31:0] wd,
                        output logic [31:0] rd, output int n);
    int m;
    n = 0;
    m = 0;
    @(posedge ref_clk);
    #1;
    hostIn.csN = 1'b0;
    hostIn.wrN = !wr;
    hostIn.rdN = wr;
    hostIn.adr = adr;
    hostIn.lowerHalfEnableN = loN;
    hostIn.upperHalfEnableN = upN;
    hostIn.data = wr ? wd : ~hostIn.data;
    while (n < 40 && ackN !== 1'b0)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    rd = busLvl;
    hostIn.wrN = 1'b1;
    hostIn.rdN = 1'b1;
    hostIn.csN = 1'b1;
    hostIn.data = ~hostIn.data;
    if (loN != `HBP_EN_ON || upN != `HBP_EN_ON)
    begin
      hostIn.lowerHalfEnableN = `HBP_EN_OFF;
      hostIn.upperHalfEnableN = `HBP_EN_OFF;
    end
    while (m < 8 && ackN !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
      m++;
    end
    if (n >= 40 || m >= 8)
      n = 99;
  endtask

endmodule // hbp_host_model

// File: sim/tb.sv
`timescale 1ns/10ps
`include "hbp_defines.svh"

module tb;
  import hbp_pkg::*;

  logic                   ref_clk;
  logic                   rst;
  hbp_host_t              hostIn;
  logic [31:0]            dataOut;
  logic [31:0]            dataOeN;
  logic                   ackN;
  logic                   srq;
  logic                   hostInterrupt;
  logic                   encodeMode;
  logic                   softResetBit;
  logic                   srqMask;
  hbp_reg_t               coreAcc;
  hbp_reg_t               lastAcc;
  logic [31:0]            coreRdData;
  logic [31:0]            strmInData;
  logic                   strmInValid;
  logic                   strmInReady;
  logic [31:0]            strmOutData;
  logic                   strmOutValid;
  logic                   strmOutReady;
  int                     errors;
  int                     comparisons;
  logic [31:0]            rd;
  int                     n;

  hbp_host_port uut
  (
    .ref_clk(ref_clk), .rst(rst), .hostIn(hostIn), .dataOut(dataOut), .dataOeN(dataOeN),
    .ackN(ackN), .bufferServiceRequest(srq), .hostInterrupt(hostInterrupt),
    .encodeMode(encodeMode), .softResetBit(softResetBit), .srqMask(srqMask),
    .coreAcc(coreAcc), .coreRdData(coreRdData), .strmInData(strmInData),
    .strmInValid(strmInValid), .strmInReady(strmInReady), .strmOutData(strmOutData),
    .strmOutValid(strmOutValid), .strmOutReady(strmOutReady)
  );

  hbp_host_model host
  (
    .ref_clk(ref_clk), .dataOut(dataOut), .dataOeN(dataOeN), .ackN(ackN), .hostIn(hostIn)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Keeps the last access that the port handed to the register file.
  always @(posedge ref_clk)
    if (coreAcc.wrEn === 1'b1 || coreAcc.rdEn === 1'b1)
      lastAcc <= coreAcc;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic acc(input logic wr, input logic [1:0] adr, input logic [1:0] lo,
                     input logic [1:0] up, input logic [31:0] wd);
    host.access(wr, adr, lo, up, wd, rd, n);
    if (n == 99)
    begin
      errors++;
      $display("[ERR] %0t access hangs", $time);
      stop_test();
    end
    cyc(1);
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset_cs();
    check(ackN, 1'b1);
    check(dataOeN, 32'hFFFF_FFFF);
    check(srq, 1'b1);
    check(hostInterrupt, 1'b0);
    host.hostIn.rdN = 1'b0;
    cyc(4);
    check(dataOeN, 32'hFFFF_FFFF);
    check(ackN, 1'b1);
    host.hostIn.rdN = 1'b1;
    $display("test reset and select done");
  endtask

  task automatic t_indirect();
    acc(1'b1, `HBP_ADR_INDADDR, `HBP_EN_ON, `HBP_EN_ON, 32'h0000_0005);
    acc(1'b1, `HBP_ADR_INDDATA, `HBP_EN_ON, `HBP_EN_ON, 32'hA5A5_0001);
    check(n, 32'h0000_0002);
    check(lastAcc.index, 8'h05);
    check(lastAcc.data, 32'hA5A5_0001);
    check(lastAcc.adr, `HBP_ADR_INDDATA);
    acc(1'b1, `HBP_ADR_INDDATA, `HBP_EN_ON, `HBP_EN_OFF, 32'h0000_1234);
    check(lastAcc.index, 8'h06);
    check({lastAcc.lowerHalf, lastAcc.upperHalf}, 2'h2);
    acc(1'b1, `HBP_ADR_INDDATA, `HBP_EN_OFF, `HBP_EN_ON, 32'h5678_0000);
    check(lastAcc.index, 8'h06);
    check({lastAcc.lowerHalf, lastAcc.upperHalf}, 2'h1);
    acc(1'b0, `HBP_ADR_INDDATA, `HBP_EN_ON, `HBP_EN_ON, 32'h0000_0000);
    check(rd, 32'hC0DE_0010);
    check(lastAcc.index, 8'h07);
    check({lastAcc.wrEn, lastAcc.rdEn}, 2'h1);
    $display("test indirect done");
  endtask

  task automatic t_decode();
    acc(1'b1, `HBP_ADR_CDATA, `HBP_EN_ON, `HBP_EN_OFF, 32'h0000_1111);
    check(n, 32'h0000_0001);
    check(strmOutValid, 1'b0);
    acc(1'b1, `HBP_ADR_CDATA, `HBP_EN_OFF, `HBP_EN_ON, 32'h2222_0000);
    check(strmOutValid, 1'b1);
    check(strmOutData, 32'h2222_1111);
    for (int i = 1; i < 32; i++)
      acc(1'b1, `HBP_ADR_CDATA, `HBP_EN_ON, `HBP_EN_ON, 32'(i));
    check(srq, 1'b0);
    fork
      acc(1'b1, `HBP_ADR_CDATA, `HBP_EN_ON, `HBP_EN_ON, 32'hFFFF_0000);
      begin
        cyc(8);
        strmOutReady = 1'b1;
        cyc(1);
        strmOutReady = 1'b0;
      end
    join
    check(32'(n > 8), 32'h0000_0001);
    check(strmOutData, 32'h0000_0001);
    $display("test decode done");
  endtask

  task automatic t_encode();
    encodeMode = 1'b1;
    softResetBit = 1'b1;
    cyc(2);
    softResetBit = 1'b0;
    cyc(2);
    check(srq, 1'b0);
    fork
      acc(1'b0, `HBP_ADR_CDATA, `HBP_EN_ON, `HBP_EN_ON, 32'h0000_0000);
      begin
        cyc(6);
        strmInData = 32'hBEEF_0001;
        strmInValid = 1'b1;
        cyc(1);
        strmInValid = 1'b0;
      end
    join
    check(32'(n > 6), 32'h0000_0001);
    check(rd, 32'hBEEF_0001);
    strmInValid = 1'b1;
    cyc(24);
    strmInValid = 1'b0;
    cyc(2);
    check(srq, 1'b1);
    check(strmInReady, 1'b1);
    check(hostInterrupt, 1'b0);
    srqMask = 1'b1;
    cyc(2);
    check(hostInterrupt, 1'b1);
    acc(1'b0, `HBP_ADR_INTSTAT, `HBP_EN_ON, `HBP_EN_ON, 32'h0000_0000);
    check(rd[0], 1'b1);
    check(n, 32'h0000_0002);
    srqMask = 1'b0;
    cyc(2);
    check(hostInterrupt, 1'b0);
    $display("test encode done");
  endtask

  initial
  begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    encodeMode = 1'b0;
    softResetBit = 1'b0;
    srqMask = 1'b0;
    coreRdData = 32'hC0DE_0010;
    strmInData = 32'h0000_0000;
    strmInValid = 1'b0;
    strmOutReady = 1'b0;
    cyc(20);
    rst = 1'b0;
    cyc(2);
    t_reset_cs();
    t_indirect();
    t_decode();
    t_encode();
    stop_test();
  end

endmodule // tb
